/* File: core/ebc_cycle_unit.sv */
// External bus cycle sequencer for a 16-bit external data bus
`timescale 1ns/1ps
module ebc_cycle_unit #(
   parameter int PAGE_BITS = ebc_pkg::EBC_PAGE_BITS
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_enable,
   input wire logic i_req_valid,
   input wire ebc_pkg::ebc_req_t i_req,
   output logic o_req_ready,
   output logic o_done,
   output logic [ebc_pkg::EBC_WORD_W-1:0] o_rdata,
   input wire logic [ebc_pkg::EBC_REGIONS-1:0][ebc_pkg::EBC_WAIT_W-1:0]
      i_region_wait_count,
   input wire logic i_page_rom_cycle_select,
   input wire logic i_page_rom_onpage_wait,
   input wire logic i_internal_long_wait,
   input wire logic i_ready_n,
   input wire logic [ebc_pkg::EBC_BUS_W-1:0] i_data_in,
   output logic [ebc_pkg::EBC_BUS_W-1:0] o_data_out,
   output logic o_data_oe,
   output logic [ebc_pkg::EBC_ADDR_W-1:0] o_addr,
   output logic o_upper_byte_enable_n,
   output logic [ebc_pkg::EBC_REGIONS-1:0] o_region_select_n,
   output ebc_pkg::ebc_strobe_t o_strobe
);
   import ebc_pkg::*;

   ebc_state_t state_q;
   ebc_req_t cur_q;
   logic [EBC_WAIT_W-1:0] wait_q;
   logic onpage_q;
   logic [EBC_ADDR_W-1:0] page_q;
   logic page_valid_q;
   logic ready_n_s;
   logic [EBC_BUS_W-1:0] data_s;
   logic in_t1;
   logic in_t2;
   logic ignore_ready;
   logic end_ok;
   logic last_end;
   logic take;
   logic cur_prom;
   logic next_onpage;
   logic [EBC_WAIT_W-1:0] wait_load;
   logic [EBC_WORD_W-1:0] wmerged;

   ebc_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_ready_sync (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_enable(i_enable),
      .i_async(i_ready_n),
      .o_sync(ready_n_s)
   );

   ebc_sync #(
      .WIDTH(EBC_BUS_W),
      .RESET_VAL('0)
   ) u_data_sync (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_enable(i_enable),
      .i_async(i_data_in),
      .o_sync(data_s)
   );

   function automatic logic is_prom(input ebc_req_t r, input logic sel);
      is_prom = sel && r.kind == EBC_K_MEM && !r.write &&
         r.region == EBC_PROM_REGION;
   endfunction : is_prom

   function automatic logic on_page(input ebc_req_t r,
                                    input logic [EBC_ADDR_W-1:0] pg);
      on_page = r.addr[EBC_ADDR_W-1:PAGE_BITS] == pg[EBC_ADDR_W-1:PAGE_BITS];
   endfunction : on_page

   assign in_t1 = state_q == EBC_ST_T1 || state_q == EBC_ST_T1S;
   assign in_t2 = state_q == EBC_ST_T2 || state_q == EBC_ST_T2S;
   assign cur_prom = is_prom(cur_q, i_page_rom_cycle_select);
   // Internal and page-ROM cycles run on their own wait counts
   assign ignore_ready = cur_prom || cur_q.kind == EBC_K_INT_IO;
   // Counter must drain and ready must be seen: the larger count wins
   assign end_ok = in_t2 && wait_q == EBC_WAIT_ZERO &&
      (ignore_ready || !ready_n_s);
   assign last_end = end_ok &&
      (state_q == EBC_ST_T2S || cur_q.size != EBC_SZ_WORD);
   assign o_req_ready = i_enable && (state_q == EBC_ST_IDLE || last_end);
   assign take = o_req_ready && i_req_valid;
   assign next_onpage = take && is_prom(i_req, i_page_rom_cycle_select) &&
      cur_prom && page_valid_q && on_page(i_req, page_q);

   // Bytes not kept carry their original value back to memory
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmerged[b*8 +: 8] = cur_q.byte_keep[b] ?
            cur_q.wdata[b*8 +: 8] : cur_q.orig[b*8 +: 8];
      end
   end

   always_comb begin
      if (cur_q.kind == EBC_K_INT_IO) begin
         wait_load = i_internal_long_wait ?
            EBC_INT_WAIT_LONG : EBC_INT_WAIT_SHORT;
      end else if (cur_prom && onpage_q) begin
         wait_load = i_page_rom_onpage_wait ?
            EBC_WAIT_ONE : EBC_WAIT_ZERO;
      end else if (cur_prom) begin
         wait_load = i_region_wait_count[EBC_PROM_REGION];
      end else begin
         wait_load = i_region_wait_count[cur_q.region];
      end
   end

   // Sequencer
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_q <= EBC_ST_IDLE;
      end else if (i_enable) begin
         case (state_q)
            EBC_ST_IDLE: begin
               if (take) begin
                  state_q <= EBC_ST_T1;
               end
            end
            EBC_ST_T1: begin
               state_q <= EBC_ST_T2;
            end
            EBC_ST_T1S: begin
               state_q <= EBC_ST_T2S;
            end
            EBC_ST_T2, EBC_ST_T2S: begin
               if (end_ok && !last_end) begin
                  state_q <= EBC_ST_T1S;
               end else if (last_end) begin
                  state_q <= take ? EBC_ST_T1 : EBC_ST_IDLE;
               end
            end
            default: begin
               state_q <= EBC_ST_IDLE;
            end
         endcase
      end
   end

   // Request capture and page tracking
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         cur_q <= '0;
         onpage_q <= 1'b0;
         page_q <= '0;
         page_valid_q <= 1'b0;
      end else if (i_enable) begin
         if (take) begin
            cur_q <= i_req;
            onpage_q <= is_prom(i_req, i_page_rom_cycle_select) &&
               cur_prom && page_valid_q && on_page(i_req, page_q) &&
               state_q != EBC_ST_IDLE;
            // Page tracks the cycle in flight, so the next take compares
            // against the cycle that is ending
            page_valid_q <= is_prom(i_req, i_page_rom_cycle_select);
            page_q <= i_req.addr;
         end
      end
   end

   // Wait counter loaded in the first state
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wait_q <= EBC_WAIT_ZERO;
      end else if (i_enable) begin
         if (in_t1) begin
            wait_q <= wait_load;
         end else if (in_t2 && wait_q != EBC_WAIT_ZERO) begin
            wait_q <= wait_q - EBC_WAIT_ONE;
         end
      end
   end

   // Address, upper byte enable and region select
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_addr <= '0;
         o_upper_byte_enable_n <= 1'b1;
         o_region_select_n <= EBC_SELECT_NONE;
      end else if (i_enable) begin
         if (take) begin
            o_addr <= i_req.addr;
            o_upper_byte_enable_n <= i_req.size == EBC_SZ_BYTE &&
               !i_req.addr[0];
            o_region_select_n <= EBC_SELECT_NONE;
            if (i_req.kind != EBC_K_INT_IO) begin
               o_region_select_n[i_req.region] <= 1'b0;
            end
         end else if (end_ok && !last_end) begin
            o_addr[1] <= 1'b1;
         end else if (last_end) begin
            o_region_select_n <= EBC_SELECT_NONE;
         end
      end
   end

   // Strobes fall to active within the first state, rise back to idle at ready end unless an on-page page-ROM read follows
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_strobe <= EBC_STROBE_IDLE;
      end else if (i_enable) begin
         if (in_t1 && cur_q.kind == EBC_K_EXT_IO) begin
            o_strobe.io_read_strobe_n <= cur_q.write;
            o_strobe.io_write_strobe_n <= !cur_q.write;
         end else if (in_t1 && cur_q.kind == EBC_K_MEM) begin
            o_strobe.memory_read_strobe_n <= cur_q.write;
            o_strobe.lower_memory_write_strobe_n <= !cur_q.write;
            o_strobe.upper_memory_write_strobe_n <= !cur_q.write;
         end else if (end_ok) begin
            o_strobe <= EBC_STROBE_IDLE;
            if (next_onpage) begin
               o_strobe.memory_read_strobe_n <= 1'b0;
            end
         end
      end
   end

   // Write data: set within first state, held through the next one
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_data_out <= '0;
         o_data_oe <= 1'b0;
      end else if (i_enable) begin
         if (in_t1) begin
            o_data_oe <= cur_q.write && cur_q.kind != EBC_K_INT_IO;
            if (cur_q.size == EBC_SZ_BYTE) begin
               // Both halves carry the byte; the unused half repeats it
               o_data_out <= {wmerged[7:0], wmerged[7:0]};
            end else if (state_q == EBC_ST_T1S) begin
               o_data_out <= wmerged[31:16];
            end else begin
               o_data_out <= wmerged[15:0];
            end
         end else if (state_q == EBC_ST_IDLE) begin
            o_data_oe <= 1'b0;
         end
      end
   end

   // Read capture on the ready end of each cycle of a read not marked discard
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_rdata <= '0;
         o_done <= 1'b0;
      end else if (i_enable) begin
         o_done <= last_end;
         if (end_ok && !cur_q.write && !cur_q.discard) begin
            if (cur_q.size == EBC_SZ_BYTE) begin
               o_rdata <= {24'h00_0000, cur_q.addr[0] ?
                  data_s[15:8] : data_s[7:0]};
            end else if (state_q == EBC_ST_T2S) begin
               o_rdata[31:16] <= data_s;
            end else begin
               o_rdata[15:0] <= data_s;
            end
         end
      end
   end

   a_short_one_cycle:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_enable && state_q == EBC_ST_T2 && end_ok &&
      cur_q.size != EBC_SZ_WORD |=> state_q != EBC_ST_T1S)
      else $error("non-word access took a second cycle");

   a_word_second_cycle:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_enable && state_q == EBC_ST_T2 && end_ok &&
      cur_q.size == EBC_SZ_WORD |=> state_q == EBC_ST_T1S ##1
      (!i_enable || o_addr[1]))
      else $error("word access missed its second cycle");

   a_ube_level:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      in_t2 |-> o_upper_byte_enable_n ==
      (cur_q.size == EBC_SZ_BYTE && !cur_q.addr[0]))
      else $error("upper byte enable wrong");

   a_io_read_strobe:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      in_t2 && cur_q.kind == EBC_K_EXT_IO && !cur_q.write |->
      !o_strobe.io_read_strobe_n && !o_region_select_n[cur_q.region])
      else $error("io read strobe or select missing");

   a_ready_ends_cycle:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_enable && in_t2 && wait_q == EBC_WAIT_ZERO && !ready_n_s |=>
      !in_t2 || $past(end_ok && !last_end))
      else $error("ready did not end the cycle");

   a_wait_floor:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      i_enable && in_t1 && cur_q.kind != EBC_K_INT_IO && !cur_prom |=>
      wait_q == $past(i_region_wait_count[cur_q.region]))
      else $error("programmed wait not loaded");

   a_internal_quiet:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      in_t2 && cur_q.kind == EBC_K_INT_IO |->
      o_strobe == EBC_STROBE_IDLE && o_region_select_n == EBC_SELECT_NONE)
      else $error("internal cycle drove a strobe");

   a_sram_write_strobes:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      in_t2 && cur_q.kind == EBC_K_MEM && cur_q.write |->
      !o_strobe.lower_memory_write_strobe_n &&
      !o_strobe.upper_memory_write_strobe_n && o_data_oe)
      else $error("sram write strobes not both active");

   a_word_write_halves:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      state_q == EBC_ST_T2S && cur_q.write |-> o_data_out == wmerged[31:16])
      else $error("upper half not on bus in second cycle");

   a_prom_ignores_ready:
   assert property (@(posedge i_clock) disable iff (i_sys_rst)
      in_t2 && cur_prom && wait_q == EBC_WAIT_ZERO |-> end_ok)
      else $error("page-rom cycle waited on ready");
endmodule : ebc_cycle_unit

/* File: core/ebc_pkg.sv */
// Shared types and constants of the external bus cycle unit
package ebc_pkg;
   localparam int EBC_ADDR_W = 24;
   localparam int EBC_BUS_W = 16;
   localparam int EBC_WORD_W = 32;
   localparam int EBC_WAIT_W = 3;
   localparam int EBC_REGIONS = 4;
   localparam int EBC_PAGE_BITS = 3;
   localparam logic [1:0] EBC_PROM_REGION = 2'h3;
   localparam logic [EBC_WAIT_W-1:0] EBC_WAIT_ZERO = 3'h0;
   localparam logic [EBC_WAIT_W-1:0] EBC_WAIT_ONE = 3'h1;
   localparam logic [EBC_WAIT_W-1:0] EBC_INT_WAIT_SHORT = 3'h1;
   localparam logic [EBC_WAIT_W-1:0] EBC_INT_WAIT_LONG = 3'h2;
   localparam logic [3:0] EBC_SELECT_NONE = 4'hf;
   localparam logic [3:0] EBC_KEEP_ALL = 4'hf;

   typedef enum logic [1:0] {
      EBC_SZ_BYTE = 2'h0,
      EBC_SZ_HALF = 2'h1,
      EBC_SZ_WORD = 2'h2
   } ebc_size_t;

   typedef enum logic [1:0] {
      EBC_K_EXT_IO = 2'h0,
      EBC_K_INT_IO = 2'h1,
      EBC_K_MEM = 2'h2
   } ebc_kind_t;

   typedef enum logic [4:0] {
      EBC_ST_IDLE = 5'h01,
      EBC_ST_T1 = 5'h02,
      EBC_ST_T2 = 5'h04,
      EBC_ST_T1S = 5'h08,
      EBC_ST_T2S = 5'h10
   } ebc_state_t;

   typedef struct packed {
      logic write;
      ebc_kind_t kind;
      ebc_size_t size;
      logic [1:0] region;
      logic discard;
      logic [3:0] byte_keep;
      logic [EBC_WORD_W-1:0] wdata;
      logic [EBC_WORD_W-1:0] orig;
      logic [EBC_ADDR_W-1:0] addr;
   } ebc_req_t;

   typedef struct packed {
      logic io_read_strobe_n;
      logic io_write_strobe_n;
      logic memory_read_strobe_n;
      logic lower_memory_write_strobe_n;
      logic upper_memory_write_strobe_n;
   } ebc_strobe_t;

   localparam ebc_strobe_t EBC_STROBE_IDLE = 5'h1f;
endpackage : ebc_pkg

/* File: core/ebc_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ebc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_enable,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   // Stage one feeds stage two only
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         meta_q <= RESET_VAL;
         o_sync <= RESET_VAL;
      end else if (i_enable) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : ebc_sync

/* File: verif/ebc_ext_dev_model.sv */
// Model of the memories and I/O devices on the 16-bit external bus
`timescale 1ns/1ps
module ebc_ext_dev_model (
   input wire logic i_clock,
   input wire logic [ebc_pkg::EBC_ADDR_W-1:0] i_addr,
   input wire logic i_upper_byte_enable_n,
   input wire logic [ebc_pkg::EBC_REGIONS-1:0] i_region_select_n,
   input wire ebc_pkg::ebc_strobe_t i_strobe,
   input wire logic [ebc_pkg::EBC_BUS_W-1:0] i_data_out,
   input wire logic i_data_oe,
   input wire logic [1:0] i_ready_mode,
   input wire logic [3:0] i_ready_delay,
   output logic o_ready_n,
   output logic [ebc_pkg::EBC_BUS_W-1:0] o_data
);
   import ebc_pkg::*;
   logic [7:0] mem [0:63];
   logic [15:0] pat_q = 16'ha5c3;
   logic [3:0] age_q = 4'h0;
   logic act;
   logic wr;
   logic strb;
   initial for (int i = 0; i < 64; i++) mem[i] = 8'h0;
   assign act = (i_region_select_n != EBC_SELECT_NONE) ||
      !i_strobe.memory_read_strobe_n || !i_strobe.io_read_strobe_n;
   assign wr = !i_strobe.lower_memory_write_strobe_n ||
      !i_strobe.upper_memory_write_strobe_n || !i_strobe.io_write_strobe_n;
   // Ready belongs to one strobed cycle; select may stay low back to back
   assign strb = wr || !i_strobe.memory_read_strobe_n ||
      !i_strobe.io_read_strobe_n;
   // Unselected bus toggles so a stale value can never pass as read data
   assign o_data = act ? ({~i_addr[8:1], i_addr[8:1]} ^
      {i_addr[16:9], 8'h5a}) : pat_q;
   // Slow devices hold ready off until their data has settled
   always_comb begin
      case (i_ready_mode)
         2'h0: o_ready_n = 1'b0;
         2'h1: o_ready_n = !(strb && age_q >= i_ready_delay);
         default: o_ready_n = 1'b1;
      endcase
   end
   // An undriven bus writes the inverted byte, so a missing enable shows
   always @(posedge i_clock) begin
      pat_q <= ~pat_q;
      age_q <= !strb ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
      if (wr && !i_addr[0]) begin
         mem[i_addr[5:0]] <= i_data_oe ? i_data_out[7:0] : ~i_data_out[7:0];
      end
      if (wr && !i_upper_byte_enable_n) begin
         mem[{i_addr[5:1], 1'b1}] <= i_data_oe ? i_data_out[15:8] :
            ~i_data_out[15:8];
      end
   end
endmodule : ebc_ext_dev_model

/* File: verif/ebc_cycle_unit_tb.sv */
// Self-checking bench of the external bus cycle unit
`timescale 1ns/1ps
module ebc_cycle_unit_tb;
   import ebc_pkg::*;
   typedef struct {
      ebc_req_t r;
      int lat;
      logic [31:0] exp;
      logic [31:0] msk;
   } ebc_tb_item_t;
   logic clk = 0;
   logic rst = 1;
   logic en = 1;
   logic req_valid = 0;
   ebc_req_t req = '0;
   logic [3:0][2:0] rwait = '0;
   logic prom_sel = 0;
   logic onpage_w = 0;
   logic int_long = 0;
   logic [1:0] rmode = 2'h0;
   logic ready_n, req_ready, done, oe, ube_n;
   logic [15:0] din, dout;
   logic [31:0] rdata, last_rd;
   logic [23:0] addr;
   logic [3:0] sel_n;
   ebc_strobe_t strobe;
   ebc_tb_item_t sq[$], tq[$], cur, it_d;
   ebc_req_t r;
   int tcyc[$];
   int cyc = 0, c_d, n_fail = 0, check_count = 0, act_cnt = 0, rise_cnt = 0;
   bit take_pend = 0;
   logic mrd_prev = 1;
   logic [7:0] sh [0:63];

   ebc_cycle_unit u_dut (.i_clock(clk), .i_sys_rst(rst), .i_enable(en),
      .i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
      .o_done(done), .o_rdata(rdata), .i_region_wait_count(rwait),
      .i_page_rom_cycle_select(prom_sel), .i_page_rom_onpage_wait(onpage_w),
      .i_internal_long_wait(int_long), .i_ready_n(ready_n), .i_data_in(din),
      .o_data_out(dout), .o_data_oe(oe), .o_addr(addr),
      .o_upper_byte_enable_n(ube_n), .o_region_select_n(sel_n),
      .o_strobe(strobe));
   ebc_ext_dev_model u_dev (.i_clock(clk), .i_addr(addr),
      .i_upper_byte_enable_n(ube_n), .i_region_select_n(sel_n),
      .i_strobe(strobe), .i_data_out(dout), .i_data_oe(oe),
      .i_ready_mode(rmode), .i_ready_delay(4'h8), .o_ready_n(ready_n),
      .o_data(din));

   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   task automatic chk_data(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_data

   task automatic chk_lat(input int e, input int g);
      check_count++;
      if (g != e) begin
         n_fail++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : chk_lat

   task automatic final_report();
      $display("checks=%0d failures=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [15:0] bus_word(input logic [23:0] a);
      return {~a[8:1], a[8:1]} ^ {a[16:9], 8'h5a};
   endfunction : bus_word

   function automatic ebc_req_t rnd_req();
      ebc_req_t q;
      q = '0;
      q.write = 1'($urandom_range(1, 0));
      q.kind = $urandom_range(1, 0) ? EBC_K_MEM : EBC_K_EXT_IO;
      q.size = ebc_size_t'($urandom_range(2, 0));
      q.region = 2'($urandom_range(3, 0));
      q.byte_keep = EBC_KEEP_ALL;
      q.wdata = $urandom();
      q.orig = $urandom();
      q.addr = {18'h0, 6'($urandom_range(63, 0))} &
         ~((24'h1 << int'(q.size)) - 24'h1);
      return q;
   endfunction : rnd_req

   // Queue one request with its expected latency, data and memory effect
   task automatic put(input ebc_req_t q, input bit onp, input bit chk,
      input bit slow);
      ebc_tb_item_t it;
      logic [15:0] lo;
      int w;
      int a;
      lo = bus_word(q.addr);
      a = int'(q.addr[5:0]);
      if (q.kind == EBC_K_INT_IO) w = int_long ? 2 : 1;
      else if (prom_sel && q.region == EBC_PROM_REGION && !q.write &&
         q.kind == EBC_K_MEM) w = onp ? int'(onpage_w) : int'(rwait[3]);
      else w = int'(rwait[q.region]);
      it.r = q;
      it.lat = (q.size == EBC_SZ_WORD) ? 4 + 2 * w : 2 + w;
      if (slow) it.lat = -it.lat;
      it.msk = '1;
      case (q.size)
         EBC_SZ_BYTE: it.exp = {24'h0, q.addr[0] ? lo[15:8] : lo[7:0]};
         EBC_SZ_HALF: it.exp = {16'h0, lo};
         default: it.exp = {bus_word(q.addr | 24'h2), lo};
      endcase
      if (q.size == EBC_SZ_HALF) it.msk = 32'h0000_ffff;
      if (q.discard) it.exp = last_rd;
      else if (!q.write) last_rd = it.exp;
      if (q.write || !chk) it.msk = '0;
      if (q.write && q.kind != EBC_K_INT_IO) begin
         for (int i = 0; i < (1 << int'(q.size)); i++) begin
            sh[a + i] = q.byte_keep[i] ? q.wdata[8*i +: 8] : q.orig[8*i +: 8];
         end
      end
      sq.push_back(it);
   endtask : put

   task automatic drain();
      int n;
      n = 0;
      while ((sq.size() > 0 || tq.size() > 0 || req_valid) && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk_lat(1, int'(n < 2000));
      @(negedge clk);
   endtask : drain

   task automatic mem_cmp();
      for (int i = 0; i < 64; i++) begin
         chk_data({24'h0, sh[i]}, {24'h0, u_dev.mem[i]});
      end
   endtask : mem_cmp

   // Results are checked and requests presented off the sampling edge
   always @(negedge clk) begin
      if (done === 1'b1) begin
         if (tq.size() == 0) chk_lat(0, 1);
         else begin
            it_d = tq.pop_front();
            c_d = tcyc.pop_front();
            if (it_d.lat >= 0) chk_lat(it_d.lat, cyc - c_d);
            else chk_lat(1, int'(cyc - c_d > -it_d.lat));
            chk_data(it_d.exp & it_d.msk, rdata & it_d.msk);
         end
      end
      if (take_pend) begin
         tq.push_back(cur);
         tcyc.push_back(cyc);
      end
      if (take_pend || !req_valid) begin
         req_valid = sq.size() > 0;
         if (req_valid) cur = sq.pop_front();
         if (req_valid) req = cur.r;
      end
      take_pend = req_valid && req_ready === 1'b1 && en;
      if (strobe !== EBC_STROBE_IDLE || sel_n !== EBC_SELECT_NONE) act_cnt++;
      if (!mrd_prev && strobe.memory_read_strobe_n) rise_cnt++;
      mrd_prev = strobe.memory_read_strobe_n;
   end

   initial begin
      #500_000;
      chk_lat(0, 1);
      final_report();
   end

   initial begin
      void'($urandom(19));
      for (int i = 0; i < 64; i++) sh[i] = 8'h0;
      repeat (10) @(negedge clk);
      rst = 0;
      for (int i = 0; i < 4; i++) rwait[i] = 3'($urandom_range(7, 2));
      en = 0;
      for (int i = 0; i < 40; i++) put(rnd_req(), 0, 1, 0);
      repeat (5) @(negedge clk);
      en = 1;
      drain();
      mem_cmp();
      rwait = '0;
      for (int i = 0; i < 20; i++) begin
         r = rnd_req();
         r.write = 1;
         put(r, 0, 0, 0);
      end
      drain();
      mem_cmp();
      rwait = {4{3'h2}};
      for (int i = 0; i < 6; i++) begin
         r = rnd_req();
         r.write = 1;
         r.size = EBC_SZ_WORD;
         r.addr[1:0] = 2'h0;
         r.byte_keep = 4'($urandom());
         for (int b = 0; b < 4; b++) r.orig[8*b +: 8] = sh[r.addr[5:0] + b];
         put(r, 0, 0, 0);
         r.write = 0;
         put(r, 0, 1, 0);
         r.discard = 1;
         put(r, 0, 1, 0);
      end
      drain();
      mem_cmp();
      rmode = 2'h1;
      for (int i = 0; i < 4; i++) begin
         r = rnd_req();
         r.write = 0;
         r.kind = EBC_K_EXT_IO;
         put(r, 0, 1, 1);
      end
      drain();
      rmode = 2'h2;
      rwait = '1;
      for (int k = 0; k < 2; k++) begin
         int_long = k[0];
         act_cnt = 0;
         for (int i = 0; i < 4; i++) begin
            r = rnd_req();
            r.kind = EBC_K_INT_IO;
            put(r, 0, 0, 0);
         end
         drain();
         chk_lat(0, act_cnt);
      end
      prom_sel = 1;
      rwait[3] = 3'h5;
      onpage_w = 1'($urandom_range(1, 0));
      rise_cnt = 0;
      r = '0;
      r.kind = EBC_K_MEM;
      r.size = EBC_SZ_HALF;
      r.region = EBC_PROM_REGION;
      for (int i = 0; i < 3; i++) begin
         r.addr = 24'h8 + 24'(2 * i);
         put(r, i > 0, i == 0, 0);
      end
      drain();
      chk_lat(1, rise_cnt);
      final_report();
   end
endmodule : ebc_cycle_unit_tb
